// *** rab_consts.vh ***
// constants for the regulator A/B setting bank
// Contract
// - stepdown1 sleep bits count only when mode zero
// - stepdown3 sleep bits count only when mode zero
// - stepdown2 sleep bits count only when mode zero
// - A active, A sleep 0: forced PWM
// - A active, A sleep 1: forced PFM
// - B active: B sleep selects PWM or PFM
// - stepdown1 code: 300 mV plus 10 mV steps
// - stepdown3 code: 530 mV plus 10 mV steps
// - stepdown2 code: 800 mV plus 20 mV steps
// - linear code: 900 mV at 0x02, 50 mV steps
// - linear codes clamp to 0x02 and 0x38
// - linear A selected with sleep set: sleep
// - linear B active with sleep set: sleep
// - mode field: 00 sleep bit, 01/10/11 fixed
`ifndef RAB_CONSTS_VH
`define RAB_CONSTS_VH

// register offsets
`define RAB_OFF_SD1_CFG     9'h09e
`define RAB_OFF_SD3_CFG     9'h09f
`define RAB_OFF_SD2_CFG     9'h0a0
`define RAB_OFF_SD1_A       9'h0a4
`define RAB_OFF_SD3_A       9'h0a5
`define RAB_OFF_SD2_A       9'h0a7
`define RAB_OFF_LN1_A       9'h0a9
`define RAB_OFF_LN2_A       9'h0aa
`define RAB_OFF_LN3_A       9'h0ab
`define RAB_OFF_LN4_A       9'h0ac
`define RAB_OFF_SD1_B       9'h0b5
`define RAB_OFF_SD3_B       9'h0b6
`define RAB_OFF_SD2_B       9'h0b8
`define RAB_OFF_LN1_B       9'h0ba
`define RAB_OFF_LN2_B       9'h0bb

// reset values
`define RAB_RST_REG         8'h00
`define RAB_RD_UNMAPPED     8'h00

// field positions
`define RAB_SLEEP_BIT       7
`define RAB_MODE_HI         7
`define RAB_MODE_LO         6
`define RAB_SD_CODE_HI      6
`define RAB_LN_CODE_HI      5

// mode encodings (field and output)
`define RAB_MODE_BY_SLEEP   2'h0
`define RAB_MODE_PFM        2'h1
`define RAB_MODE_PWM        2'h2
`define RAB_MODE_AUTO       2'h3

// voltage mapping in mV
`define RAB_SD1_BASE_MV     12'h12c
`define RAB_SD1_STEP_MV     12'h00a
`define RAB_SD3_BASE_MV     12'h212
`define RAB_SD3_STEP_MV     12'h00a
`define RAB_SD2_BASE_MV     12'h320
`define RAB_SD2_STEP_MV     12'h014
`define RAB_LN_BASE_MV      12'h384
`define RAB_LN_STEP_MV      12'h032
`define RAB_LN_CODE_MIN     6'h02
`define RAB_LN_CODE_MAX     6'h38

`endif

// *** rab_stepdown_decode.v ***
// step-down converter setting decode: code, target level and mode
`timescale 1ns/1ps
module rab_stepdown_decode #(
    parameter [11:0] BASE_MV = 12'h12c,
    parameter [11:0] STEP_MV = 12'h00a
) (
    // chosen settings
    input  wire [7:0]  setting_a,
    input  wire [7:0]  setting_b,
    input  wire        sel_b,
    input  wire [1:0]  mode_field,
    // decoded result
    output wire [6:0]  code,
    output wire [11:0] level_mv,
    output reg  [1:0]  mode
);
`include "rab_consts.vh"

    wire [7:0]  chosen;
    wire        sleep_bit;
    wire [11:0] offset_mv;

    assign chosen    = sel_b ? setting_b : setting_a;
    assign sleep_bit = chosen[`RAB_SLEEP_BIT];
    assign code      = chosen[`RAB_SD_CODE_HI:0];
    assign offset_mv = {5'h00, code} * STEP_MV;
    assign level_mv  = BASE_MV + offset_mv;

    // sleep bits only matter while the mode field is zero
    always @* begin
        case (mode_field)
            `RAB_MODE_BY_SLEEP: begin
                if (sleep_bit)
                    mode = `RAB_MODE_PFM;
                else
                    mode = `RAB_MODE_PWM;
            end
            default: mode = mode_field;
        endcase
    end
endmodule

// *** rab_linear_decode.v ***
// linear regulator setting decode with code clamping
`timescale 1ns/1ps
module rab_linear_decode (
    // chosen settings
    input  wire [7:0]  setting_a,
    input  wire [7:0]  setting_b,
    input  wire        sel_b,
    // decoded result
    output wire [5:0]  code,
    output wire [11:0] level_mv,
    output wire        sleep
);
`include "rab_consts.vh"

    wire [7:0]  chosen;
    wire [11:0] offset_mv;

    function [5:0] clamp_code;
        input [5:0] raw;
        begin
            if (raw < `RAB_LN_CODE_MIN)
                clamp_code = `RAB_LN_CODE_MIN;
            else if (raw > `RAB_LN_CODE_MAX)
                clamp_code = `RAB_LN_CODE_MAX;
            else
                clamp_code = raw;
        end
    endfunction

    assign chosen    = sel_b ? setting_b : setting_a;
    // bit 6 is kept in the register but never looked at here
    assign code      = clamp_code(chosen[`RAB_LN_CODE_HI:0]);
    assign offset_mv = {6'h00, code - `RAB_LN_CODE_MIN} * `RAB_LN_STEP_MV;
    assign level_mv  = `RAB_LN_BASE_MV + offset_mv;
    assign sleep     = chosen[`RAB_SLEEP_BIT];
endmodule

// *** rab_setting_bank.v ***
// regulator A/B setting register bank with decoded, registered outputs
`timescale 1ns/1ps
module rab_setting_bank (
    // clock and reset
    input  wire        mclk,
    input  wire        arst_n,
    // register access from the 2-wire port
    input  wire [8:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_ack,
    output reg         reg_hit,
    // setting selects, 1 picks B
    input  wire        stepdown1_sel_b,
    input  wire        stepdown2_sel_b,
    input  wire        stepdown3_sel_b,
    input  wire        linear1_sel_b,
    input  wire        linear2_sel_b,
    // first step-down converter
    output reg  [6:0]  stepdown1_code,
    output reg  [11:0] stepdown1_mv,
    output reg  [1:0]  stepdown1_mode,
    // second step-down converter
    output reg  [6:0]  stepdown2_code,
    output reg  [11:0] stepdown2_mv,
    output reg  [1:0]  stepdown2_mode,
    // third step-down converter
    output reg  [6:0]  stepdown3_code,
    output reg  [11:0] stepdown3_mv,
    output reg  [1:0]  stepdown3_mode,
    // linear regulators
    output reg  [5:0]  linear1_code,
    output reg  [11:0] linear1_mv,
    output reg         linear1_sleep,
    output reg  [5:0]  linear2_code,
    output reg  [11:0] linear2_mv,
    output reg         linear2_sleep,
    output reg  [5:0]  linear3_code,
    output reg  [11:0] linear3_mv,
    output reg         linear3_sleep,
    output reg  [5:0]  linear4_code,
    output reg  [11:0] linear4_mv,
    output reg         linear4_sleep
);
`include "rab_consts.vh"

    // configuration registers holding the mode fields
    reg  [7:0]  stepdown1_cfg_r;
    reg  [7:0]  stepdown2_cfg_r;
    reg  [7:0]  stepdown3_cfg_r;
    // setting registers
    reg  [7:0]  stepdown1_setting_a_r;
    reg  [7:0]  stepdown2_setting_a_r;
    reg  [7:0]  stepdown3_setting_a_r;
    reg  [7:0]  linear1_setting_a_r;
    reg  [7:0]  linear2_setting_a_r;
    reg  [7:0]  linear3_setting_a_r;
    reg  [7:0]  linear4_setting_a_r;
    reg  [7:0]  stepdown1_setting_b_r;
    reg  [7:0]  stepdown2_setting_b_r;
    reg  [7:0]  stepdown3_setting_b_r;
    reg  [7:0]  linear1_setting_b_r;
    reg  [7:0]  linear2_setting_b_r;

    // read path
    reg  [7:0]  rdata_nxt;
    reg         hit_nxt;

    // decoded values
    wire [6:0]  sd1_code;
    wire [11:0] sd1_mv;
    wire [1:0]  sd1_mode;

    wire [6:0]  sd2_code;
    wire [11:0] sd2_mv;
    wire [1:0]  sd2_mode;

    wire [6:0]  sd3_code;
    wire [11:0] sd3_mv;
    wire [1:0]  sd3_mode;

    wire [5:0]  ln1_code;
    wire [11:0] ln1_mv;
    wire        ln1_sleep;

    wire [5:0]  ln2_code;
    wire [11:0] ln2_mv;
    wire        ln2_sleep;

    wire [5:0]  ln3_code;
    wire [11:0] ln3_mv;
    wire        ln3_sleep;

    wire [5:0]  ln4_code;
    wire [11:0] ln4_mv;
    wire        ln4_sleep;

    wire [1:0]  sd1_mode_field;
    wire [1:0]  sd2_mode_field;
    wire [1:0]  sd3_mode_field;

    assign sd1_mode_field = stepdown1_cfg_r[`RAB_MODE_HI:`RAB_MODE_LO];
    assign sd2_mode_field = stepdown2_cfg_r[`RAB_MODE_HI:`RAB_MODE_LO];
    assign sd3_mode_field = stepdown3_cfg_r[`RAB_MODE_HI:`RAB_MODE_LO];

    // writes: every bit is read/write, reserved ones included
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stepdown1_cfg_r       <= `RAB_RST_REG;
            stepdown2_cfg_r       <= `RAB_RST_REG;
            stepdown3_cfg_r       <= `RAB_RST_REG;
            stepdown1_setting_a_r <= `RAB_RST_REG;
            stepdown2_setting_a_r <= `RAB_RST_REG;
            stepdown3_setting_a_r <= `RAB_RST_REG;
            linear1_setting_a_r   <= `RAB_RST_REG;
            linear2_setting_a_r   <= `RAB_RST_REG;
            linear3_setting_a_r   <= `RAB_RST_REG;
            linear4_setting_a_r   <= `RAB_RST_REG;
            stepdown1_setting_b_r <= `RAB_RST_REG;
            stepdown2_setting_b_r <= `RAB_RST_REG;
            stepdown3_setting_b_r <= `RAB_RST_REG;
            linear1_setting_b_r   <= `RAB_RST_REG;
            linear2_setting_b_r   <= `RAB_RST_REG;
        end else if (reg_wr) begin
            if (reg_addr == `RAB_OFF_SD1_CFG)
                stepdown1_cfg_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_SD3_CFG)
                stepdown3_cfg_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_SD2_CFG)
                stepdown2_cfg_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_SD1_A)
                stepdown1_setting_a_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_SD3_A)
                stepdown3_setting_a_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_SD2_A)
                stepdown2_setting_a_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_LN1_A)
                linear1_setting_a_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_LN2_A)
                linear2_setting_a_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_LN3_A)
                linear3_setting_a_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_LN4_A)
                linear4_setting_a_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_SD1_B)
                stepdown1_setting_b_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_SD3_B)
                stepdown3_setting_b_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_SD2_B)
                stepdown2_setting_b_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_LN1_B)
                linear1_setting_b_r <= reg_wdata;
            else if (reg_addr == `RAB_OFF_LN2_B)
                linear2_setting_b_r <= reg_wdata;
        end
    end

    // read decode; unmapped offsets read as zero with hit low
    always @* begin
        hit_nxt   = 1'b1;
        rdata_nxt = `RAB_RD_UNMAPPED;
        if (reg_addr == `RAB_OFF_SD1_CFG)
            rdata_nxt = stepdown1_cfg_r;
        else if (reg_addr == `RAB_OFF_SD3_CFG)
            rdata_nxt = stepdown3_cfg_r;
        else if (reg_addr == `RAB_OFF_SD2_CFG)
            rdata_nxt = stepdown2_cfg_r;
        else if (reg_addr == `RAB_OFF_SD1_A)
            rdata_nxt = stepdown1_setting_a_r;
        else if (reg_addr == `RAB_OFF_SD3_A)
            rdata_nxt = stepdown3_setting_a_r;
        else if (reg_addr == `RAB_OFF_SD2_A)
            rdata_nxt = stepdown2_setting_a_r;
        else if (reg_addr == `RAB_OFF_LN1_A)
            rdata_nxt = linear1_setting_a_r;
        else if (reg_addr == `RAB_OFF_LN2_A)
            rdata_nxt = linear2_setting_a_r;
        else if (reg_addr == `RAB_OFF_LN3_A)
            rdata_nxt = linear3_setting_a_r;
        else if (reg_addr == `RAB_OFF_LN4_A)
            rdata_nxt = linear4_setting_a_r;
        else if (reg_addr == `RAB_OFF_SD1_B)
            rdata_nxt = stepdown1_setting_b_r;
        else if (reg_addr == `RAB_OFF_SD3_B)
            rdata_nxt = stepdown3_setting_b_r;
        else if (reg_addr == `RAB_OFF_SD2_B)
            rdata_nxt = stepdown2_setting_b_r;
        else if (reg_addr == `RAB_OFF_LN1_B)
            rdata_nxt = linear1_setting_b_r;
        else if (reg_addr == `RAB_OFF_LN2_B)
            rdata_nxt = linear2_setting_b_r;
        else
            hit_nxt = 1'b0;
    end

    // answer one cycle after the strobe; rdata holds until the next read
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= `RAB_RD_UNMAPPED;
            reg_ack   <= 1'b0;
            reg_hit   <= 1'b0;
        end else begin
            reg_ack <= reg_rd | reg_wr;
            if (reg_rd | reg_wr)
                reg_hit <= hit_nxt;
            if (reg_rd)
                reg_rdata <= rdata_nxt;
        end
    end

    // step-down converters
    rab_stepdown_decode #(
        .BASE_MV (`RAB_SD1_BASE_MV),
        .STEP_MV (`RAB_SD1_STEP_MV)
    ) u_sd1 (
        .setting_a  (stepdown1_setting_a_r),
        .setting_b  (stepdown1_setting_b_r),
        .sel_b      (stepdown1_sel_b),
        .mode_field (sd1_mode_field),
        .code       (sd1_code),
        .level_mv   (sd1_mv),
        .mode       (sd1_mode)
    );

    rab_stepdown_decode #(
        .BASE_MV (`RAB_SD2_BASE_MV),
        .STEP_MV (`RAB_SD2_STEP_MV)
    ) u_sd2 (
        .setting_a  (stepdown2_setting_a_r),
        .setting_b  (stepdown2_setting_b_r),
        .sel_b      (stepdown2_sel_b),
        .mode_field (sd2_mode_field),
        .code       (sd2_code),
        .level_mv   (sd2_mv),
        .mode       (sd2_mode)
    );

    rab_stepdown_decode #(
        .BASE_MV (`RAB_SD3_BASE_MV),
        .STEP_MV (`RAB_SD3_STEP_MV)
    ) u_sd3 (
        .setting_a  (stepdown3_setting_a_r),
        .setting_b  (stepdown3_setting_b_r),
        .sel_b      (stepdown3_sel_b),
        .mode_field (sd3_mode_field),
        .code       (sd3_code),
        .level_mv   (sd3_mv),
        .mode       (sd3_mode)
    );

    // linear regulators; 3 and 4 have no B register here, so they stay on A
    rab_linear_decode u_ln1 (
        .setting_a (linear1_setting_a_r),
        .setting_b (linear1_setting_b_r),
        .sel_b     (linear1_sel_b),
        .code      (ln1_code),
        .level_mv  (ln1_mv),
        .sleep     (ln1_sleep)
    );

    rab_linear_decode u_ln2 (
        .setting_a (linear2_setting_a_r),
        .setting_b (linear2_setting_b_r),
        .sel_b     (linear2_sel_b),
        .code      (ln2_code),
        .level_mv  (ln2_mv),
        .sleep     (ln2_sleep)
    );

    rab_linear_decode u_ln3 (
        .setting_a (linear3_setting_a_r),
        .setting_b (linear3_setting_a_r),
        .sel_b     (1'b0),
        .code      (ln3_code),
        .level_mv  (ln3_mv),
        .sleep     (ln3_sleep)
    );

    rab_linear_decode u_ln4 (
        .setting_a (linear4_setting_a_r),
        .setting_b (linear4_setting_a_r),
        .sel_b     (1'b0),
        .code      (ln4_code),
        .level_mv  (ln4_mv),
        .sleep     (ln4_sleep)
    );

    // outputs are registered so the analog side sees glitch-free levels
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stepdown1_code <= 7'h00;
            stepdown1_mv   <= `RAB_SD1_BASE_MV;
            stepdown1_mode <= `RAB_MODE_PWM;

            stepdown2_code <= 7'h00;
            stepdown2_mv   <= `RAB_SD2_BASE_MV;
            stepdown2_mode <= `RAB_MODE_PWM;

            stepdown3_code <= 7'h00;
            stepdown3_mv   <= `RAB_SD3_BASE_MV;
            stepdown3_mode <= `RAB_MODE_PWM;

            linear1_code   <= `RAB_LN_CODE_MIN;
            linear1_mv     <= `RAB_LN_BASE_MV;
            linear1_sleep  <= 1'b0;

            linear2_code   <= `RAB_LN_CODE_MIN;
            linear2_mv     <= `RAB_LN_BASE_MV;
            linear2_sleep  <= 1'b0;

            linear3_code   <= `RAB_LN_CODE_MIN;
            linear3_mv     <= `RAB_LN_BASE_MV;
            linear3_sleep  <= 1'b0;

            linear4_code   <= `RAB_LN_CODE_MIN;
            linear4_mv     <= `RAB_LN_BASE_MV;
            linear4_sleep  <= 1'b0;
        end else begin
            stepdown1_code <= sd1_code;
            stepdown1_mv   <= sd1_mv;
            stepdown1_mode <= sd1_mode;

            stepdown2_code <= sd2_code;
            stepdown2_mv   <= sd2_mv;
            stepdown2_mode <= sd2_mode;

            stepdown3_code <= sd3_code;
            stepdown3_mv   <= sd3_mv;
            stepdown3_mode <= sd3_mode;

            linear1_code   <= ln1_code;
            linear1_mv     <= ln1_mv;
            linear1_sleep  <= ln1_sleep;

            linear2_code   <= ln2_code;
            linear2_mv     <= ln2_mv;
            linear2_sleep  <= ln2_sleep;

            linear3_code   <= ln3_code;
            linear3_mv     <= ln3_mv;
            linear3_sleep  <= ln3_sleep;

            linear4_code   <= ln4_code;
            linear4_mv     <= ln4_mv;
            linear4_sleep  <= ln4_sleep;
        end
    end
endmodule

// *** rab_setting_bank_properties.sv ***
// concurrent checks on the regulator setting bank ports
`timescale 1ns/1ps
module rab_setting_bank_properties (
    // clock and reset
    input wire         mclk,
    input wire         arst_n,
    // register port
    input wire  [8:0]  reg_addr,
    input wire         reg_wr,
    input wire         reg_rd,
    input wire  [7:0]  reg_wdata,
    input logic [7:0]  reg_rdata,
    input logic        reg_ack,
    input logic        reg_hit,
    // decoded outputs
    input logic [6:0]  stepdown1_code,
    input logic [11:0] stepdown1_mv,
    input logic [1:0]  stepdown1_mode,
    input logic [6:0]  stepdown2_code,
    input logic [11:0] stepdown2_mv,
    input logic [6:0]  stepdown3_code,
    input logic [11:0] stepdown3_mv,
    input logic [5:0]  linear1_code,
    input logic [11:0] linear1_mv
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    function automatic bit mapped(logic [8:0] a);
        return a inside {9'h09e, 9'h09f, 9'h0a0, 9'h0a4, 9'h0a5, 9'h0a7, 9'h0a9, 9'h0aa, 9'h0ab, 9'h0ac,
                         9'h0b5, 9'h0b6, 9'h0b8, 9'h0ba, 9'h0bb};
    endfunction

    sequence wr_then_rd_s;
        reg_wr && !reg_rd && mapped(reg_addr) ##1 reg_rd && !reg_wr && reg_addr == $past(reg_addr);
    endsequence

    // mode lands two edges after the strobe, so the next cycle must not rewrite it
    sequence cfg1_fixed_s;
        reg_wr && reg_addr == 9'h09e && reg_wdata[7:6] != 2'h0 ##1 !reg_wr;
    endsequence

    ack_follows_strobe_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
        else $error("acknowledge missing after a strobe");
    ack_single_pulse_a: assert property (!(reg_wr || reg_rd) |=> !reg_ack)
        else $error("acknowledge without a strobe");
    write_readback_a: assert property (wr_then_rd_s |=> reg_hit && reg_rdata == $past(reg_wdata, 2))
        else $error("register read back differs from write");
    unmapped_read_a: assert property (reg_rd && !reg_wr && !mapped(reg_addr) |=> !reg_hit && reg_rdata == 8'h00)
        else $error("unmapped read not refused");
    sd1_fixed_mode_a: assert property (cfg1_fixed_s |=> {stepdown1_mode, 6'h00} == ($past(reg_wdata, 2) & 8'hc0))
        else $error("first converter mode ignores its field");
    sd1_level_a: assert property (stepdown1_mv == 12'h12c + 12'(stepdown1_code) * 12'h00a)
        else $error("first converter level wrong");
    sd2_level_a: assert property (stepdown2_mv == 12'h320 + 12'(stepdown2_code) * 12'h014)
        else $error("second converter level wrong");
    sd3_level_a: assert property (stepdown3_mv == 12'h212 + 12'(stepdown3_code) * 12'h00a)
        else $error("third converter level wrong");
    ln1_clamp_a: assert property (linear1_code inside {[6'h02:6'h38]} && linear1_mv == 12'h384 + (12'(linear1_code) - 12'h002) * 12'h032)
        else $error("linear code or level out of range");
endmodule

bind rab_setting_bank rab_setting_bank_properties u_props (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_hit(reg_hit),
    .stepdown1_code(stepdown1_code), .stepdown1_mv(stepdown1_mv), .stepdown1_mode(stepdown1_mode),
    .stepdown2_code(stepdown2_code), .stepdown2_mv(stepdown2_mv), .stepdown3_code(stepdown3_code),
    .stepdown3_mv(stepdown3_mv), .linear1_code(linear1_code), .linear1_mv(linear1_mv)
);

// *** rab_host_model.sv ***
// host side model driving the register strobe port
`timescale 1ns/1ps
module rab_host_model (
    // clock
    input  wire        mclk,
    // strobe port towards the bank
    output logic [8:0] reg_addr,
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [7:0] reg_wdata,
    input  wire  [7:0] reg_rdata,
    input  wire        reg_ack,
    input  wire        reg_hit
);
    initial begin
        reg_addr  = 9'h000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end

    // called at a falling edge; strobes stay up so a following access can run back to back
    task automatic access(input bit w, input logic [8:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic hit, output bit ok);
        reg_addr  = a;
        reg_wdata = w ? d : ~reg_wdata;
        reg_wr    = w;
        reg_rd    = !w;
        @(negedge mclk);
        for (int n = 0; n < 4 && reg_ack !== 1'b1; n++) @(negedge mclk);
        ok  = (reg_ack === 1'b1);
        q   = reg_rdata;
        hit = reg_hit;
    endtask

    // stale address and data are scrambled so nothing can lean on them
    task automatic release_port();
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
endmodule

// *** rab_setting_bank_tb.sv ***
// self-checking bench for the regulator setting bank
`timescale 1ns/1ps
module rab_setting_bank_tb;
    logic        mclk;
    logic        arst_n;
    logic [2:0]  sd_sel;
    logic [1:0]  ln_sel;
    wire  [8:0]  reg_addr;
    wire  [7:0]  reg_wdata, reg_rdata;
    wire         reg_wr, reg_rd, reg_ack, reg_hit;
    wire  [6:0]  sdc [0:2];
    wire  [11:0] sdv [0:2];
    wire  [1:0]  sdm [0:2];
    wire  [5:0]  lnc [0:3];
    wire  [11:0] lnv [0:3];
    wire         lns [0:3];
    logic [7:0]  mreg [0:511];
    int          miscompares, checks_done;
    // index 0..2 is converter 1..3
    logic [8:0]  amap [0:14] = '{9'h09e, 9'h09f, 9'h0a0, 9'h0a4, 9'h0a5, 9'h0a7, 9'h0a9, 9'h0aa,
                                 9'h0ab, 9'h0ac, 9'h0b5, 9'h0b6, 9'h0b8, 9'h0ba, 9'h0bb};
    logic [8:0]  cfg_o [0:2] = '{9'h09e, 9'h0a0, 9'h09f};
    logic [8:0]  sda_o [0:2] = '{9'h0a4, 9'h0a7, 9'h0a5};
    logic [8:0]  sdb_o [0:2] = '{9'h0b5, 9'h0b8, 9'h0b6};
    logic [8:0]  lna_o [0:3] = '{9'h0a9, 9'h0aa, 9'h0ab, 9'h0ac};
    logic [8:0]  lnb_o [0:1] = '{9'h0ba, 9'h0bb};
    int          sd_base [0:2] = '{300, 800, 530};
    int          sd_step [0:2] = '{10, 20, 10};
    logic [5:0]  ecode [0:7] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h37, 6'h38, 6'h39, 6'h3f};

    rab_setting_bank dut (
        .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_hit(reg_hit),
        .stepdown1_sel_b(sd_sel[0]), .stepdown2_sel_b(sd_sel[1]), .stepdown3_sel_b(sd_sel[2]),
        .linear1_sel_b(ln_sel[0]), .linear2_sel_b(ln_sel[1]),
        .stepdown1_code(sdc[0]), .stepdown1_mv(sdv[0]), .stepdown1_mode(sdm[0]),
        .stepdown2_code(sdc[1]), .stepdown2_mv(sdv[1]), .stepdown2_mode(sdm[1]),
        .stepdown3_code(sdc[2]), .stepdown3_mv(sdv[2]), .stepdown3_mode(sdm[2]),
        .linear1_code(lnc[0]), .linear1_mv(lnv[0]), .linear1_sleep(lns[0]),
        .linear2_code(lnc[1]), .linear2_mv(lnv[1]), .linear2_sleep(lns[1]),
        .linear3_code(lnc[2]), .linear3_mv(lnv[2]), .linear3_sleep(lns[2]),
        .linear4_code(lnc[3]), .linear4_mv(lnv[3]), .linear4_sleep(lns[3])
    );

    rab_host_model host (
        .mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_hit(reg_hit)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    function automatic bit mapped(logic [8:0] a);
        foreach (amap[i]) if (amap[i] == a) return 1'b1;
        return 1'b0;
    endfunction

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic acc(input bit w, input logic [8:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       h;
        bit         ok;
        host.access(w, a, d, q, h, ok);
        if (!ok) begin
            miscompares++;
            test_done();
        end
        chk("hit", 12'(mapped(a)), 12'(h));
        if (!w) chk("read_data", 12'(mapped(a) ? mreg[a] : 8'h00), 12'(q));
        if (w && mapped(a)) mreg[a] = d;
    endtask

    // outputs trail a write by two edges and a select by one; one idle edge covers both
    task automatic check_all();
        logic [7:0] r;
        logic [1:0] f;
        logic [5:0] c;
        host.release_port();
        @(negedge mclk);
        for (int i = 0; i < 3; i++) begin
            r = sd_sel[i] ? mreg[sdb_o[i]] : mreg[sda_o[i]];
            f = mreg[cfg_o[i]][7:6];
            chk("sd_code", 12'(r[6:0]), 12'(sdc[i]));
            chk("sd_mv", 12'(sd_base[i] + sd_step[i] * r[6:0]), sdv[i]);
            chk("sd_mode", (f != 2'h0) ? 12'(f) : (r[7] ? 12'h001 : 12'h002), 12'(sdm[i]));
        end
        for (int j = 0; j < 4; j++) begin
            r = (j < 2 && ln_sel[j]) ? mreg[lnb_o[j]] : mreg[lna_o[j]];
            c = (r[5:0] < 6'h02) ? 6'h02 : (r[5:0] > 6'h38) ? 6'h38 : r[5:0];
            chk("ln_code", 12'(c), 12'(lnc[j]));
            chk("ln_mv", 12'(900 + 50 * (c - 2)), lnv[j]);
            chk("ln_sleep", 12'(r[7]), 12'(lns[j]));
        end
    endtask

    task automatic do_reset();
        arst_n = 1'b0;
        foreach (mreg[i]) mreg[i] = 8'h00;
        repeat (6) @(negedge mclk);
        arst_n = 1'b1;
        @(negedge mclk);
    endtask

    initial begin
        #400000;
        miscompares++;
        test_done();
    end

    initial begin
        arst_n = 1'b0;
        sd_sel = 3'h0;
        ln_sel = 2'h0;
        miscompares = 0;
        checks_done = 0;
        void'($urandom(32'h27fd4d73));
        do_reset();
        foreach (amap[i]) acc(1'b0, amap[i], 8'h00);
        acc(1'b1, 9'h0a6, 8'h5a);
        acc(1'b0, 9'h0a6, 8'h00);
        acc(1'b0, 9'h1ff, 8'h00);
        check_all();
        $display("test reset_and_unmapped done");
        // every mode field value against both sleep bits and both selects
        for (int m = 0; m < 16; m++) begin
            for (int i = 0; i < 3; i++) begin
                acc(1'b1, sda_o[i], {m[2], 7'(m * 9 + i)});
                acc(1'b1, sdb_o[i], {m[3], 7'(m * 5 + 100)});
            end
            for (int i = 2; i >= 0; i--) acc(1'b1, cfg_o[i], {m[1:0], 6'h15});
            for (int s = 0; s < 2; s++) begin
                sd_sel = {3{s[0]}};
                check_all();
            end
        end
        $display("test mode_table done");
        for (int k = 0; k < 8; k++) begin
            foreach (lna_o[j]) acc(1'b1, lna_o[j], {k[0], k[1], ecode[k]});
            foreach (lnb_o[j]) acc(1'b1, lnb_o[j], {~k[0], k[2], ecode[7 - k]});
            ln_sel = 2'(k);
            check_all();
            ln_sel = ~ln_sel;
            check_all();
        end
        $display("test linear_clamp done");
        for (int n = 0; n < 120; n++) begin
            int k;
            k = $urandom_range(14);
            acc(1'b1, amap[k], 8'($urandom));
            acc(1'b0, amap[k], 8'h00);
            {sd_sel, ln_sel} = 5'($urandom);
            check_all();
        end
        $display("test random_traffic done");
        acc(1'b1, 9'h0a4, 8'hff);
        host.release_port();
        do_reset();
        foreach (amap[i]) acc(1'b0, amap[i], 8'h00);
        check_all();
        $display("test mid_run_reset done");
        test_done();
    end
endmodule
